/* File: logic/pmic_seq_pkg.sv */
// Purpose: shared constants and types for the power handshake sequencer
// Assumes: one 250 MHz core clock
// Notes: rails are ordered by start slot, slot 0 means all rails off
package pmic_seq_pkg;

  localparam longint CLK_HZ = 250_000_000;
  localparam int RAIL_COUNT = 6;
  localparam int SLOT_W = 3;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h5;
  // start slot of each sequenced rail, three bits per rail, rail 0 lowest
  localparam logic [RAIL_COUNT*SLOT_W-1:0] RAIL_SLOT = 18'h2_D8D1;

  // long hold on the button, in seconds
  localparam longint LONG_PRESS_S = 8;
  localparam longint LONG_PRESS_CYCLES = LONG_PRESS_S * CLK_HZ;
  // button must stay stable this long, in milliseconds
  localparam longint DEBOUNCE_MS = 20;
  localparam longint DEBOUNCE_CYCLES = (DEBOUNCE_MS * CLK_HZ) / 1000;
  // wake output pulse width, in nanoseconds
  localparam longint WAKE_PULSE_NS = 1000;
  localparam logic [15:0] WAKE_CYCLES =
    16'((WAKE_PULSE_NS * CLK_HZ) / 1_000_000_000);
  localparam logic [5:0] VSEL_RESET = 6'h00;

  typedef enum logic [2:0] {
    ST_NOINPUT,
    ST_STANDBY,
    ST_POWERUP,
    ST_ON,
    ST_DROP,
    ST_POWERDOWN,
    ST_OFF
  } pwr_state_t;

  typedef struct packed {
    logic dc;
    logic usb;
    logic present;
  } src_t;

  typedef struct packed {
    logic up_done;
    logic down_done;
  } seq_stat_t;

  // rails whose start slot is at or below the given slot
  function automatic logic [RAIL_COUNT-1:0] rails_upto(
    input logic [SLOT_W-1:0] slot);
    logic [RAIL_COUNT-1:0] mask;
    mask = '0;
    for (int i = 0; i < RAIL_COUNT; i++) begin
      mask[i] = (RAIL_SLOT[i*SLOT_W +: SLOT_W] <= slot);
    end
    return mask;
  endfunction

endpackage

/* File: logic/pmic_button_filter.sv */
// Purpose: synchronise and debounce the active low power button
// Assumes: button pin is asynchronous to the core clock
// Notes: pressed is a one-cycle pulse on the filtered falling edge of the pin
`timescale 1ns/10ps
`default_nettype none
module pmic_button_filter #(
  parameter int unsigned STABLE_CYCLES = 32'h004C_4B40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic button_n,
  output logic held,
  output logic pressed
);
  logic meta_n;
  logic sync_n;
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_held;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_n <= 1'b1;
      sync_n <= 1'b1;
    end else begin
      meta_n <= button_n;
      sync_n <= meta_n;
    end
  end

  // restart the count whenever the synced level matches held
  always_comb begin
    next_count = 32'h0000_0000;
    next_held = held;
    if (!sync_n != held) begin
      if (count >= STABLE_CYCLES - 32'h0000_0001) begin
        next_held = !sync_n;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
      held <= 1'b0;
    end else begin
      count <= next_count;
      held <= next_held;
    end
  end

  assign pressed = next_held && !held;
endmodule
`default_nettype wire

/* File: logic/pmic_rail_sequencer.sv */
// Purpose: steps sequenced rails on by slot and off in reverse
// Assumes: rail good inputs are regulator comparators, asynchronous
// Notes: each slot waits for its rails to report good before the next
`timescale 1ns/10ps
`default_nettype none
module pmic_rail_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go_up,
  input wire logic go_down,
  input wire logic [pmic_seq_pkg::RAIL_COUNT-1:0] rail_good,
  output logic [pmic_seq_pkg::RAIL_COUNT-1:0] rail_en,
  output var pmic_seq_pkg::seq_stat_t status
);
  logic [pmic_seq_pkg::RAIL_COUNT-1:0] good_meta;
  logic [pmic_seq_pkg::RAIL_COUNT-1:0] good;
  logic [pmic_seq_pkg::SLOT_W-1:0] slot;
  logic [pmic_seq_pkg::SLOT_W-1:0] next_slot;
  logic [pmic_seq_pkg::RAIL_COUNT-1:0] mask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      good_meta <= '0;
      good <= '0;
    end else begin
      good_meta <= rail_good;
      good <= good_meta;
    end
  end

  assign mask = pmic_seq_pkg::rails_upto(slot);

  always_comb begin
    next_slot = slot;
    if (go_down) begin
      if (slot != '0 && (good & ~mask) == '0) begin
        next_slot = slot - 3'h1;
      end
    end else if (go_up) begin
      if (slot != pmic_seq_pkg::SLOT_LAST && (good & mask) == mask) begin
        next_slot = slot + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot <= '0;
      rail_en <= '0;
    end else begin
      slot <= next_slot;
      rail_en <= pmic_seq_pkg::rails_upto(next_slot);
    end
  end

  assign status.up_done = (slot == pmic_seq_pkg::SLOT_LAST) &&
                          (good == rail_en);
  assign status.down_done = (slot == '0) && (good == '0);
endmodule
`default_nettype wire

/* File: logic/pmic_power_handshake_sequencer.sv */
// Purpose: source select, power button and power handshake with the host
// Assumes: software controls arrive from the serial port logic on CORE_CLK
// Notes: pins from outside pass two flip-flops before use
// Summary of operation
// R1: DC input wins whenever both are present
// R2: report DC or USB, accept source config
// R3: button press raises the interrupt
// R4: host drops enable request to power down
// R5: after power off, button press restarts power up
// R6: hold over 8 s shuts down, LED off
// R7: still held after shutdown, power back up
// R8: RTC rail comes up before all others
// R9: RTC rail stays on while off with input
// R10: RTC good output once RTC rail stable
// R11: host raises enable request to start power up
// R12: all rails good output after full power up
// R13: wake output pulses on button press
// R14: software rail switching and voltage select accepted
// R15: only RTC regulator starts at input power
// R16: interrupt output is open drain
// R17: button synchronised and debounced before use
// R18: all rails good drops before rails turn off
`timescale 1ns/10ps
`default_nettype none
module pmic_power_handshake_sequencer #(
  parameter int unsigned LONG_PRESS_CYCLES =
    32'(pmic_seq_pkg::LONG_PRESS_CYCLES),
  parameter int unsigned DEBOUNCE_CYCLES =
    32'(pmic_seq_pkg::DEBOUNCE_CYCLES)
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic DC_PRESENT,
  input wire logic USB_PRESENT,
  input wire logic USB_INPUT_DISABLE,
  input wire logic BUTTON_N,
  input wire logic POWER_ENABLE_REQUEST_PIN,
  input wire logic RTC_REGULATOR_GOOD,
  input wire logic [pmic_seq_pkg::RAIL_COUNT-1:0] RAIL_GOOD,
  input wire logic IRQ_ACK,
  input wire logic [pmic_seq_pkg::RAIL_COUNT-1:0] SW_RAIL_OFF,
  input wire logic [5:0] MPU_VSEL_REQ,
  output logic SOURCE_SELECT_DC,
  output logic SOURCE_SELECT_USB,
  output logic SOURCE_IS_DC,
  output logic ALWAYS_ON_RAIL_EN,
  output logic [pmic_seq_pkg::RAIL_COUNT-1:0] RAIL_EN,
  output logic RTC_A,
  output logic ALL_RAILS_GOOD,
  output logic EXTERNAL_WAKE_INPUT,
  output logic POWER_EVENT_IRQ_O,
  output logic POWER_EVENT_IRQ_OE,
  output logic IRQ_PENDING,
  output logic POWER_LED,
  output logic [5:0] MPU_VSEL
);
  logic rst_meta_n;
  logic rst_n;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic dc_sync;
  logic usb_sync;
  logic req_sync;
  logic rtc_good_sync;
  pmic_seq_pkg::src_t src;
  pmic_seq_pkg::src_t next_src;
  pmic_seq_pkg::pwr_state_t state;
  pmic_seq_pkg::pwr_state_t next_state;
  pmic_seq_pkg::seq_stat_t seq_stat;
  logic [pmic_seq_pkg::RAIL_COUNT-1:0] seq_en;
  logic [pmic_seq_pkg::RAIL_COUNT-1:0] next_rail_en;
  logic held;
  logic pressed;
  logic long_flag;
  logic next_long_flag;
  logic [31:0] hold_count;
  logic [31:0] next_hold_count;
  logic long_hit;
  logic irq;
  logic next_irq;
  logic [15:0] wake_count;
  logic [15:0] next_wake_count;
  logic next_rtc_en;
  logic next_rtc_a;
  logic next_all_good;
  logic [5:0] next_vsel;

  // reset release through two flip-flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {DC_PRESENT, USB_PRESENT, POWER_ENABLE_REQUEST_PIN,
                   RTC_REGULATOR_GOOD};
      pin_sync <= pin_meta;
    end
  end

  assign dc_sync = pin_sync[3];
  assign usb_sync = pin_sync[2];
  assign req_sync = pin_sync[1];
  assign rtc_good_sync = pin_sync[0];

  pmic_button_filter #(
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) u_button (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .button_n(BUTTON_N), // see R17
    .held(held),
    .pressed(pressed)
  );

  pmic_rail_sequencer u_rails (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .go_up(state == pmic_seq_pkg::ST_POWERUP ||
           state == pmic_seq_pkg::ST_ON), // see R8
    .go_down(state == pmic_seq_pkg::ST_POWERDOWN ||
             state == pmic_seq_pkg::ST_NOINPUT), // see R18
    .rail_good(RAIL_GOOD),
    .rail_en(seq_en),
    .status(seq_stat)
  );

  // source selection, DC has priority
  always_comb begin
    next_src.dc = dc_sync; // see R1
    next_src.usb = usb_sync && !dc_sync && !USB_INPUT_DISABLE; // see R2
    next_src.present = next_src.dc || next_src.usb;
  end

  assign long_hit = held && (hold_count == LONG_PRESS_CYCLES - 32'h1);

  // main power state machine
  always_comb begin
    next_state = state;
    next_long_flag = long_flag;
    case (state)
      pmic_seq_pkg::ST_NOINPUT: begin
        next_long_flag = 1'b0;
        if (src.present) begin
          next_state = pmic_seq_pkg::ST_STANDBY; // see R15
        end
      end
      pmic_seq_pkg::ST_STANDBY: begin
        if (req_sync && RTC_A) begin
          next_state = pmic_seq_pkg::ST_POWERUP; // see R11
        end
      end
      pmic_seq_pkg::ST_POWERUP, pmic_seq_pkg::ST_ON: begin
        if (long_hit) begin
          next_long_flag = 1'b1; // see R6
          next_state = pmic_seq_pkg::ST_DROP;
        end else if (!req_sync) begin
          next_state = pmic_seq_pkg::ST_DROP; // see R4
        end else if (seq_stat.up_done) begin
          next_state = pmic_seq_pkg::ST_ON;
        end
      end
      pmic_seq_pkg::ST_DROP: begin
        next_state = pmic_seq_pkg::ST_POWERDOWN; // see R18
      end
      pmic_seq_pkg::ST_POWERDOWN: begin
        if (seq_stat.down_done) begin
          next_long_flag = 1'b0;
          if (long_flag && held) begin
            next_state = pmic_seq_pkg::ST_STANDBY; // see R7
          end else begin
            next_state = pmic_seq_pkg::ST_OFF;
          end
        end
      end
      pmic_seq_pkg::ST_OFF: begin
        if (pressed) begin
          next_state = pmic_seq_pkg::ST_STANDBY; // see R5
        end
      end
      default: begin
        next_state = pmic_seq_pkg::ST_NOINPUT;
      end
    endcase
    if (!src.present) begin
      next_state = pmic_seq_pkg::ST_NOINPUT;
    end
  end

  // hold timer, interrupt, wake and outputs
  always_comb begin
    next_hold_count = 32'h0000_0000;
    if (held && (state == pmic_seq_pkg::ST_ON ||
                 state == pmic_seq_pkg::ST_POWERUP) && !long_hit) begin
      next_hold_count = hold_count + 32'h0000_0001; // see R6
    end
    next_irq = pressed || (irq && !IRQ_ACK); // see R3
    next_wake_count = (wake_count != 16'h0000) ?
                      wake_count - 16'h0001 : 16'h0000;
    if (pressed) begin
      next_wake_count = pmic_seq_pkg::WAKE_CYCLES; // see R13
    end
    // rtc rail stays on until the last sequenced rail drops on input loss
    next_rtc_en = src.present || (seq_en != '0); // see R9
    next_rtc_a = ALWAYS_ON_RAIL_EN && rtc_good_sync; // see R10
    next_all_good = (state == pmic_seq_pkg::ST_ON) &&
                    (next_state == pmic_seq_pkg::ST_ON); // see R12
    next_rail_en = seq_en;
    next_vsel = MPU_VSEL;
    if (state == pmic_seq_pkg::ST_ON) begin
      next_rail_en = seq_en & ~SW_RAIL_OFF; // see R14
      next_vsel = MPU_VSEL_REQ; // see R14
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      src <= '0;
      state <= pmic_seq_pkg::ST_NOINPUT;
      long_flag <= 1'b0;
      hold_count <= 32'h0000_0000;
      irq <= 1'b0;
      wake_count <= 16'h0000;
      ALWAYS_ON_RAIL_EN <= 1'b0;
      RTC_A <= 1'b0;
      ALL_RAILS_GOOD <= 1'b0;
      RAIL_EN <= '0;
      MPU_VSEL <= pmic_seq_pkg::VSEL_RESET;
    end else begin
      src <= next_src;
      state <= next_state;
      long_flag <= next_long_flag;
      hold_count <= next_hold_count;
      irq <= next_irq;
      wake_count <= next_wake_count;
      ALWAYS_ON_RAIL_EN <= next_rtc_en;
      RTC_A <= next_rtc_a;
      ALL_RAILS_GOOD <= next_all_good;
      RAIL_EN <= next_rail_en;
      MPU_VSEL <= next_vsel;
    end
  end

  assign SOURCE_SELECT_DC = src.dc;
  assign SOURCE_SELECT_USB = src.usb;
  assign SOURCE_IS_DC = src.dc; // see R2
  assign EXTERNAL_WAKE_INPUT = (wake_count != 16'h0000);
  assign POWER_EVENT_IRQ_O = 1'b0; // see R16
  assign POWER_EVENT_IRQ_OE = irq; // see R16
  assign IRQ_PENDING = irq;
  assign POWER_LED = ALL_RAILS_GOOD; // see R6

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  a_dc_priority_select: assert property ( // see R1
    dc_sync |=> SOURCE_IS_DC && !SOURCE_SELECT_USB)
    else $error("DC input not preferred");
  a_press_raises_irq: assert property ( // see R3
    pressed |=> POWER_EVENT_IRQ_OE && !POWER_EVENT_IRQ_O)
    else $error("button press did not raise interrupt");
  a_irq_held_till_ack: assert property ( // see R3
    irq && !IRQ_ACK |=> irq)
    else $error("interrupt dropped without acknowledge");
  a_wake_pulse_width: assert property ( // see R13
    pressed |=> EXTERNAL_WAKE_INPUT [*8])
    else $error("wake pulse too short");
  a_rtc_first_rail: assert property ( // see R8
    RAIL_EN != '0 |-> ALWAYS_ON_RAIL_EN)
    else $error("rail enabled before RTC rail");
  a_rtc_kept_off: assert property ( // see R9
    state == pmic_seq_pkg::ST_OFF && src.present |=> ALWAYS_ON_RAIL_EN)
    else $error("RTC rail dropped in power off");
  a_rtc_good_cause: assert property ( // see R10
    RTC_A |-> $past(ALWAYS_ON_RAIL_EN) && $past(rtc_good_sync))
    else $error("RTC good without stable rail");
  a_good_needs_on: assert property ( // see R12
    ALL_RAILS_GOOD |-> $past(state) == pmic_seq_pkg::ST_ON &&
      ($past(ALL_RAILS_GOOD) || $past(seq_stat.up_done)))
    else $error("all rails good without full power up");
  a_good_drops_first: assert property ( // see R18
    $fell(ALL_RAILS_GOOD) && src.present |-> RAIL_EN == $past(RAIL_EN))
    else $error("rails dropped with all rails good");
  a_long_press_down: assert property ( // see R6
    long_hit && src.present |=> state == pmic_seq_pkg::ST_DROP ##1
      !POWER_LED)
    else $error("long hold did not shut down");
  a_press_restarts: assert property ( // see R5
    state == pmic_seq_pkg::ST_OFF && pressed && src.present |=>
      state == pmic_seq_pkg::ST_STANDBY)
    else $error("press in power off did not restart");
  a_request_down: assert property ( // see R4
    state == pmic_seq_pkg::ST_ON && !req_sync && src.present |=>
      state == pmic_seq_pkg::ST_DROP ##1
      state == pmic_seq_pkg::ST_POWERDOWN)
    else $error("request low did not start power down");
endmodule
`default_nettype wire

/* File: dv/pmic_host_model.sv */
// Purpose: host processor and regulator comparators for the sequencer
// Assumes: rail good follows rail enable after a regulator delay
// Notes: slow adds one cycle of regulator delay
`timescale 1ns/10ps
`default_nettype none
module pmic_host_model (
  input wire logic clk,
  input wire logic want_on,
  input wire logic slow,
  input wire logic rtc_a,
  input wire logic aor_en,
  input wire logic [pmic_seq_pkg::RAIL_COUNT-1:0] rail_en,
  output logic req,
  output logic rtc_good,
  output logic [pmic_seq_pkg::RAIL_COUNT-1:0] rail_good
);
  logic [pmic_seq_pkg::RAIL_COUNT-1:0] d1;
  logic [pmic_seq_pkg::RAIL_COUNT-1:0] d2;
  initial begin
    req = 1'b0;
    rtc_good = 1'b0;
    rail_good = '0;
    d1 = '0;
    d2 = '0;
  end
  always @(posedge clk) begin
    d1 <= rail_en;
    d2 <= d1;
    rail_good <= slow ? d2 : d1;
    rtc_good <= aor_en;
    // request only once the rtc domain is released, low to power down
    req <= want_on & rtc_a;
  end
endmodule
`default_nettype wire

/* File: dv/pmic_power_handshake_sequencer_test.sv */
// Purpose: scenario bench for the power handshake sequencer
// Assumes: short long-press and debounce counts
// Notes: inputs change by non-blocking assignment 1 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
module pmic_power_handshake_sequencer_test;
  logic CORE_CLK, RESETN, DC_PRESENT, USB_PRESENT, USB_INPUT_DISABLE;
  logic BUTTON_N, REQ, RTC_GOOD, IRQ_ACK, WANT_ON, SLOW;
  logic [5:0] RAIL_GOOD, SW_RAIL_OFF, MPU_VSEL_REQ, RAIL_EN, MPU_VSEL;
  logic SEL_DC, SEL_USB, IS_DC, AOR_EN, RTC_A, AGOOD, WAKE;
  logic IRQ_O, IRQ_OE, IRQ_PENDING, LED;
  int fail_count, checks, cycles;

  pmic_power_handshake_sequencer #(
    .LONG_PRESS_CYCLES(200), .DEBOUNCE_CYCLES(4)
  ) pmic_power_handshake_sequencer_i (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .DC_PRESENT(DC_PRESENT),
    .USB_PRESENT(USB_PRESENT), .USB_INPUT_DISABLE(USB_INPUT_DISABLE),
    .BUTTON_N(BUTTON_N), .POWER_ENABLE_REQUEST_PIN(REQ),
    .RTC_REGULATOR_GOOD(RTC_GOOD), .RAIL_GOOD(RAIL_GOOD),
    .IRQ_ACK(IRQ_ACK), .SW_RAIL_OFF(SW_RAIL_OFF),
    .MPU_VSEL_REQ(MPU_VSEL_REQ), .SOURCE_SELECT_DC(SEL_DC),
    .SOURCE_SELECT_USB(SEL_USB), .SOURCE_IS_DC(IS_DC),
    .ALWAYS_ON_RAIL_EN(AOR_EN), .RAIL_EN(RAIL_EN), .RTC_A(RTC_A),
    .ALL_RAILS_GOOD(AGOOD), .EXTERNAL_WAKE_INPUT(WAKE),
    .POWER_EVENT_IRQ_O(IRQ_O), .POWER_EVENT_IRQ_OE(IRQ_OE),
    .IRQ_PENDING(IRQ_PENDING), .POWER_LED(LED), .MPU_VSEL(MPU_VSEL)
  );
  pmic_host_model pmic_host_model_i (
    .clk(CORE_CLK), .want_on(WANT_ON), .slow(SLOW), .rtc_a(RTC_A),
    .aor_en(AOR_EN), .rail_en(RAIL_EN), .req(REQ),
    .rtc_good(RTC_GOOD), .rail_good(RAIL_GOOD)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask

  // sel 0 waits on all rails good, sel 1 on the rail enables
  task automatic wait_sig(input logic sel, input logic [5:0] v);
    int n;
    n = 0;
    while ((sel ? RAIL_EN : {5'h0, AGOOD}) !== v && n < 1000) begin
      tick(1);
      n++;
    end
    chk(8'(n < 1000), 8'h01);
  endtask

  task automatic press(input int n);
    BUTTON_N <= 1'b0;
    tick(n);
    BUTTON_N <= 1'b1;
    tick(1);
  endtask

  task automatic t_source();
    USB_PRESENT <= 1'b1;
    tick(6);
    chk({5'h0, SEL_USB, IS_DC, SEL_DC}, 8'h04);
    USB_INPUT_DISABLE <= 1'b1;
    tick(4);
    chk(8'(SEL_USB), 8'h00);
    USB_INPUT_DISABLE <= 1'b0;
    DC_PRESENT <= 1'b1;
    tick(6);
    chk({5'h0, SEL_USB, IS_DC, SEL_DC}, 8'h03);
    chk({AOR_EN, 1'b0, RAIL_EN}, 8'h80);
    chk(8'(RTC_A), 8'h01);
  endtask

  task automatic t_up();
    WANT_ON <= 1'b1;
    wait_sig(1'b1, 6'h01);
    chk({AGOOD, 1'b0, RAIL_EN}, 8'h01);
    wait_sig(1'b0, 6'h01);
    chk({LED, 1'b0, RAIL_EN}, 8'hBF);
  endtask

  task automatic t_button();
    press(2);
    tick(8);
    chk({6'h0, IRQ_OE, WAKE}, 8'h00);
    press(12);
    chk({4'h0, IRQ_O, IRQ_OE, IRQ_PENDING, WAKE}, 8'h07);
    tick(300);
    chk({6'h0, IRQ_OE, WAKE}, 8'h02);
    IRQ_ACK <= 1'b1;
    tick(1);
    IRQ_ACK <= 1'b0;
    tick(2);
    chk(8'(IRQ_OE), 8'h00);
  endtask

  task automatic t_soft();
    MPU_VSEL_REQ <= 6'h2A;
    SW_RAIL_OFF <= 6'h20;
    tick(10);
    chk({2'h0, MPU_VSEL}, 8'h2A);
    chk({2'h0, RAIL_EN}, 8'h1F);
    SW_RAIL_OFF <= 6'h00;
    tick(10);
    chk({2'h0, RAIL_EN}, 8'h3F);
  endtask

  task automatic t_down();
    WANT_ON <= 1'b0;
    wait_sig(1'b0, 6'h00);
    chk({2'h0, RAIL_EN}, 8'h3F);
    wait_sig(1'b1, 6'h00);
    chk({6'h0, AOR_EN, RTC_A}, 8'h03);
    WANT_ON <= 1'b1;
    tick(30);
    chk({2'h0, RAIL_EN}, 8'h00);
    press(12);
    wait_sig(1'b0, 6'h01);
  endtask

  task automatic t_long();
    BUTTON_N <= 1'b0;
    tick(150);
    chk(8'(AGOOD), 8'h01);
    wait_sig(1'b0, 6'h00);
    chk(8'(LED), 8'h00);
    wait_sig(1'b1, 6'h00);
    wait_sig(1'b1, 6'h01);
    BUTTON_N <= 1'b1;
    wait_sig(1'b0, 6'h01);
    BUTTON_N <= 1'b0;
    wait_sig(1'b0, 6'h00);
    BUTTON_N <= 1'b1;
    wait_sig(1'b1, 6'h00);
    tick(40);
    chk({AGOOD, 1'b0, RAIL_EN}, 8'h00);
  endtask

  initial begin
    fail_count = 0;
    checks = 0;
    cycles = 0;
    RESETN = 1'b0;
    {DC_PRESENT, USB_PRESENT, USB_INPUT_DISABLE, IRQ_ACK} = 4'h0;
    BUTTON_N = 1'b1;
    WANT_ON = 1'b0;
    SLOW = 1'b0;
    SW_RAIL_OFF = 6'h00;
    MPU_VSEL_REQ = 6'h00;
    tick(5);
    chk({RAIL_EN, AGOOD, IRQ_OE}, 8'h00);
    chk({RTC_A, AOR_EN, MPU_VSEL}, 8'h00);
    RESETN <= 1'b1;
    tick(4);
    t_source();
    t_up();
    t_button();
    t_soft();
    t_down();
    SLOW <= 1'b1;
    t_long();
    test_done();
  end
endmodule
`default_nettype wire
